// ### logic/utmi_data_handshake.sv
// Transceiver-side transmit/receive handshake of the 16-bit data bus.
`timescale 1ns/1ps

module utmi_data_handshake (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Link side of the shared bus.
    input wire logic TXVALID,
    output logic TXREADY,
    input wire logic [utmi_hs_pkg::DATA_W-1:0] DATA_I,
    output logic [utmi_hs_pkg::DATA_W-1:0] DATA_O,
    output logic [utmi_hs_pkg::DATA_W-1:0] DATA_OE,
    input wire logic VALIDH_I,
    output logic VALIDH_O,
    output logic VALIDH_OE,
    output logic RXVALID,
    output logic RXACTIVE,
    output logic RXERROR,
    // Core side: transmit holding register drain.
    input wire logic TX_TAKE,
    output utmi_hs_pkg::word_t TX_WORD,
    output logic TX_FULL,
    // Core side: receive state machine.
    input wire logic RX_SOP,
    input wire logic RX_EOP,
    input wire logic RX_LOAD,
    input wire utmi_hs_pkg::word_t RX_WORD,
    input wire logic RX_ERR
);

    ////////////////////////////////////////////////////////////////////////
    // Lane view of the data pins.

    // A lane is one byte of the bus; lane 0 is the low byte, which is
    // valid in every transfer, and the qualifier speaks for the rest.
    localparam int unsigned byte_w = utmi_hs_pkg::BYTE_W;
    localparam int unsigned lane_count = utmi_hs_pkg::DATA_W / byte_w;

    typedef logic [lane_count-1:0][byte_w-1:0] lanes_t;

    localparam lanes_t lane_rst = utmi_hs_pkg::DATA_RST;

    lanes_t data_in_lanes;

    assign data_in_lanes = DATA_I;

    // Only the transmit side packs lanes and qualifier into a word; receive
    // reads the fields of RX_WORD by name. One function keeps the bit order.
    function automatic utmi_hs_pkg::word_t pack_word(input lanes_t lanes,
                                                     input logic high);
        return '{data: lanes, high_valid: high};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Transmit holding register.

    logic tx_capture;
    logic tx_full_q;
    logic tx_full_d;
    logic tx_high_q;
    lanes_t tx_lane_q;

    // Ready while transmit valid is high and the holding register is empty or the core drains it this cycle, so a capture and the
    // core's drain of the previous word can share a cycle without loss.
    assign TXREADY = TXVALID && (!tx_full_q || TX_TAKE);
    assign tx_capture = TXREADY;

    // Both lanes load on every capture; after a low-byte-only transfer the
    // high lane holds bus noise, which the qualifier marks as unused.
    for (genvar lane = 0; lane < lane_count; lane++) begin : g_tx_lane
        always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
                tx_lane_q[lane] <= lane_rst[lane];
            end else if (tx_capture) begin
                tx_lane_q[lane] <= data_in_lanes[lane];
            end
        end
    end

    // The qualifier is taken on the same edge as the lanes, so the byte
    // count belongs to exactly that transfer.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_high_q <= utmi_hs_pkg::WORD_RST.high_valid;
        end else if (tx_capture) begin
            tx_high_q <= VALIDH_I;
        end
    end

    // Capture wins over a drain in the same cycle: the new word lands in
    // the register that the drain has just emptied.
    always_comb begin
        tx_full_d = tx_full_q;
        if (tx_capture) begin
            tx_full_d = 1'b1;
        end else if (TX_TAKE) begin
            tx_full_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_full_q <= 1'b0;
        end else begin
            tx_full_q <= tx_full_d;
        end
    end

    assign TX_WORD = pack_word(tx_lane_q, tx_high_q);
    assign TX_FULL = tx_full_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive holding register and status.

    logic rx_valid_q;
    logic rx_valid_d;
    logic rx_active_q;
    logic rx_active_d;
    logic rx_error_q;
    logic rx_error_d;
    logic rx_high_q;
    lanes_t rx_load_lanes;
    lanes_t rx_lane_q;

    assign rx_load_lanes = RX_WORD.data;

    // The link unloads every valid word on the edge, so a word stands one
    // cycle unless the receive machine loads again.
    always_comb begin
        rx_valid_d = RX_LOAD;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= rx_valid_d;
        end
    end

    // The lanes keep their value after the valid pulse, so the pins stay
    // quiet while the bus is released.
    for (genvar lane = 0; lane < lane_count; lane++) begin : g_rx_lane
        always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
                rx_lane_q[lane] <= lane_rst[lane];
            end else if (RX_LOAD) begin
                rx_lane_q[lane] <= rx_load_lanes[lane];
            end
        end
    end

    // The qualifier travels with the word it belongs to.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_high_q <= utmi_hs_pkg::WORD_RST.high_valid;
        end else if (RX_LOAD) begin
            rx_high_q <= RX_WORD.high_valid;
        end
    end

    // Start of packet wins over end of packet in the same cycle.
    always_comb begin
        rx_active_d = rx_active_q;
        if (RX_SOP) begin
            rx_active_d = 1'b1;
        end else if (RX_EOP) begin
            rx_active_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_active_q <= 1'b0;
        end else begin
            rx_active_q <= rx_active_d;
        end
    end

    // The error flag passes one register, like the data, so both reach
    // the link on the same edge.
    always_comb begin
        rx_error_d = RX_ERR;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_error_q <= 1'b0;
        end else begin
            rx_error_q <= rx_error_d;
        end
    end

    assign RXVALID = rx_valid_q;
    assign RXACTIVE = rx_active_q;
    assign RXERROR = rx_error_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus direction.

    logic drive_bus;

    // Direction follows the live transmit valid, so the device lets go of
    // the bus in the very cycle in which the link starts to transmit.
    function automatic logic device_drives(input logic tx_valid,
                                           input logic rx_valid);
        return !tx_valid && rx_valid;
    endfunction

    assign drive_bus = device_drives(TXVALID, rx_valid_q);

    // One enable per line, as each pad has its own output buffer.
    for (genvar pin_i = 0; pin_i < utmi_hs_pkg::DATA_W; pin_i++) begin : g_oe
        assign DATA_OE[pin_i] = drive_bus ? utmi_hs_pkg::DIR_OUT[pin_i]
                                          : utmi_hs_pkg::DIR_IN[pin_i];
    end

    assign VALIDH_OE = device_drives(TXVALID, rx_valid_q);
    assign DATA_O = rx_lane_q;
    assign VALIDH_O = rx_high_q;

endmodule // utmi_data_handshake

// ### logic/utmi_hs_pkg.sv
// Constants and carrier types for the parallel data handshake block.
//
// Notes on behaviour
// - Transmit ready says data was captured and the next transfer may follow.
// - Transmit valid high: device releases the 16-bit bus, link drives it.
// - Transmit low, receive valid high: device drives bus and qualifier.
// - Receive active rises at packet start, falls after end of packet.
// - Receive error is 1 on error, else 0, timed with the receive data.
package utmi_hs_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_W = 8;

    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DIR_IN = 16'h0000;
    localparam logic [DATA_W-1:0] DIR_OUT = 16'hFFFF;

    // One word of transmit or receive data with its high byte qualifier.
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic high_valid;
    } word_t;

    localparam word_t WORD_RST = '{data: DATA_RST, high_valid: 1'b0};

endpackage

// ### dv/utmi_data_handshake_properties.sv
// Port-level checker for the data handshake block.
`timescale 1ns/1ps
module utmi_hs_props (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic TXVALID,
    input wire logic TXREADY,
    input wire logic VALIDH_I,
    input wire logic [15:0] DATA_I,
    input wire logic [15:0] DATA_O,
    input wire logic [15:0] DATA_OE,
    input wire logic VALIDH_O,
    input wire logic VALIDH_OE,
    input wire logic RXVALID,
    input wire logic RXACTIVE,
    input wire logic RXERROR,
    input wire logic TX_TAKE,
    input wire logic TX_FULL,
    input wire logic RX_SOP,
    input wire logic RX_EOP,
    input wire logic RX_LOAD,
    input wire logic RX_ERR,
    input wire utmi_hs_pkg::word_t TX_WORD,
    input wire utmi_hs_pkg::word_t RX_WORD
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_cap;
        TXVALID && TXREADY;
    endsequence

    sequence s_load;
        RX_LOAD;
    endsequence

    chk_ready_ack: assert property (
        TXREADY == (TXVALID && (!TX_FULL || TX_TAKE)))
        else $error("ready wrong");
    chk_tx_capture: assert property (
        s_cap |=> TX_FULL && TX_WORD == {$past(DATA_I), $past(VALIDH_I)})
        else $error("capture wrong");
    chk_full_hold: assert property (
        TX_FULL && !TX_TAKE |=> TX_FULL)
        else $error("full lost");
    chk_bus_release: assert property (
        TXVALID |-> DATA_OE == 16'h0000 && !VALIDH_OE)
        else $error("bus not released");
    chk_bus_drive: assert property (
        !TXVALID && RXVALID |-> &DATA_OE && VALIDH_OE)
        else $error("bus not driven");
    chk_rx_word: assert property (
        s_load |=> RXVALID && {DATA_O, VALIDH_O} == $past(RX_WORD))
        else $error("rx word wrong");
    chk_rx_pulse: assert property (
        !RX_LOAD |=> !RXVALID)
        else $error("rx valid without load");
    chk_active_set: assert property (
        RX_SOP |=> RXACTIVE)
        else $error("active not set");
    chk_active_clear: assert property (
        RX_EOP && !RX_SOP |=> !RXACTIVE)
        else $error("active not clear");
    chk_error_follow: assert property (
        1'b1 |=> RXERROR == $past(RX_ERR))
        else $error("error wrong");
endmodule // utmi_hs_props
bind utmi_data_handshake utmi_hs_props i_props (.*);

// ### dv/sie_model.sv
// Link-side partner that drives and resolves the shared bus.
`timescale 1ns/1ps
module sie_model (
    input wire logic clk,
    input wire logic go,
    input wire logic vh_o,
    input wire logic vh_oe,
    input wire logic rxv,
    input wire utmi_hs_pkg::word_t w,
    input wire logic [15:0] d_o,
    input wire logic [15:0] oe,
    output logic txv,
    output logic vh_i,
    output logic [15:0] d_i,
    output utmi_hs_pkg::word_t got
);
    assign txv = go;
    // Released lines fall to their pull-down level.
    assign d_i = txv ? w.data : d_o & oe;
    assign vh_i = txv ? w.high_valid : vh_o & vh_oe;
    always_ff @(posedge clk) begin
        if (rxv) begin
            got <= {d_i, vh_i};
        end
    end
endmodule // sie_model

// ### dv/utmi_data_handshake_tb.sv
// Self-checking bench for the data handshake block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
    num_checks++; \
    if ((a) !== (e)) begin \
        bad_count++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, a); \
    end \
end
module utmi_data_handshake_tb;
    logic CORE_CLK = 0, RST_N = 0, TX_TAKE = 0, RX_SOP = 0, RX_EOP = 0;
    logic RX_LOAD = 0, RX_ERR = 0, go = 0, TXVALID, TXREADY, VALIDH_I;
    logic VALIDH_O, VALIDH_OE, RXVALID, RXACTIVE, RXERROR, TX_FULL;
    logic [15:0] DATA_I, DATA_O, DATA_OE;
    utmi_hs_pkg::word_t TX_WORD, RX_WORD = '0, w = '0, got;
    int bad_count = 0, num_checks = 0;
    utmi_data_handshake i_dut (.*);
    sie_model i_sie (.clk(CORE_CLK), .go(go), .vh_o(VALIDH_O),
        .vh_oe(VALIDH_OE), .rxv(RXVALID), .w(w), .d_o(DATA_O),
        .oe(DATA_OE), .txv(TXVALID), .vh_i(VALIDH_I), .d_i(DATA_I),
        .got(got));
    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    task step; @(posedge CORE_CLK); #1; endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task t_tx;
        go = 1; w = {16'hA5C3, 1'b1}; #1;
        `CHK("ready", 1'b1, TXREADY)
        `CHK("oe_in", 16'h0000, DATA_OE)
        step;
        `CHK("word", w, TX_WORD)
        `CHK("full", 1'b1, TX_FULL)
        `CHK("refused", 1'b0, TXREADY)
        step;
        `CHK("held", {16'hA5C3, 1'b1}, TX_WORD)
        TX_TAKE = 1; w = {16'h005A, 1'b0}; step;
        `CHK("word_low", w, TX_WORD)
        go = 0; step; TX_TAKE = 0;
        `CHK("drained", 1'b0, TX_FULL)
    endtask
    task t_rx;
        RX_SOP = 1; RX_LOAD = 1; RX_WORD = {16'h1234, 1'b0}; RX_ERR = 1;
        step; RX_SOP = 0; RX_ERR = 0; RX_WORD = {16'hBEEF, 1'b1}; #1;
        `CHK("oe_out", 16'hFFFF, DATA_OE)
        `CHK("vh_oe", 1'b1, VALIDH_OE)
        `CHK("vh_low", 1'b0, VALIDH_O)
        `CHK("active", 1'b1, RXACTIVE)
        `CHK("error", 1'b1, RXERROR)
        step; RX_LOAD = 0;
        `CHK("got", {16'h1234, 1'b0}, got)
        `CHK("vh_high", 1'b1, VALIDH_O)
        `CHK("err_clr", 1'b0, RXERROR)
        step;
        `CHK("got2", {16'hBEEF, 1'b1}, got)
        `CHK("rx_done", 1'b0, RXVALID)
        `CHK("oe_rel", 16'h0000, DATA_OE)
        RX_EOP = 1; step; RX_EOP = 0;
        `CHK("idle", 1'b0, RXACTIVE)
    endtask
    initial begin
        repeat (20) step;
        RST_N = 1; step;
        t_tx; t_rx; test_done;
    end
    initial begin #5000; bad_count++; test_done; end
endmodule // utmi_data_handshake_tb
